/* core/fsr_pkg.sv */
package fsr_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] REG_CALL_ARG = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_IRQ_STS  = 8'h08;
  localparam logic [7:0] REG_IRQ_CLR  = 8'h0C;
  localparam logic [7:0] REG_IRQ_EN   = 8'h10;

  localparam int STAT_BUSY  = 0;
  localparam int STAT_STALL = 1;
  localparam int STAT_PH_LO = 2;

  localparam int IRQ_PHASE = 0;
  localparam int IRQ_DONE  = 1;
  localparam int IRQ_ERR   = 2;
  localparam int IRQ_W     = 3;

  // ------------------------------------------------------------
  // Parameter block layout
  // ------------------------------------------------------------
  localparam int         WORD_BYTES = 4;
  localparam int         WORD_SHIFT = 2;
  localparam int         HDR_WORDS  = 3;
  localparam int         ROW_BYTES  = 512;
  localparam int         ROW_SHIFT  = 9;
  localparam int         FIELD_W    = 8;
  localparam int         OPC_LO     = 24;
  localparam int         BLK_LO     = 8;
  localparam int         VER_LO     = 16;
  localparam int         STALL_BIT  = 2;
  localparam int         HWP_BIT    = 1;
  localparam logic [7:0] OPC_REWRITE = 8'h05;
  localparam logic [7:0] BLOCKING_ON = 8'h01;
  localparam logic [7:0] VERIFY_ON   = 8'h01;

  // ------------------------------------------------------------
  // Result word
  // ------------------------------------------------------------
  localparam logic [3:0]  ST_OK      = 4'hA;
  localparam logic [3:0]  ST_ERR     = 4'hF;
  localparam logic [27:0] ERR_NONE   = 28'h0000000;
  localparam logic [27:0] ERR_VERIFY = 28'h0000022;
  localparam logic [27:0] ERR_ACCESS = 28'h0000010;
  localparam logic [27:0] ERR_OPCODE = 28'h0000011;
  localparam logic [27:0] ERR_ALIGN  = 28'h0000012;

  typedef enum logic [1:0] {
    FOP_NONE    = 2'h0,
    FOP_PREPROG = 2'h1,
    FOP_ERASE   = 2'h2,
    FOP_PROGRAM = 2'h3
  } fsr_fop_t;

  typedef enum logic [8:0] {
    S_IDLE   = 9'h001,
    S_FETCH  = 9'h002,
    S_CHECK  = 9'h004,
    S_PRE    = 9'h008,
    S_ERASE  = 9'h010,
    S_FILL   = 9'h020,
    S_PROG   = 9'h040,
    S_VERIFY = 9'h080,
    S_DONE   = 9'h100
  } fsr_state_t;

endpackage

/* core/fsr_sync3.sv */
`timescale 1ns/10ps
`default_nettype none
module fsr_sync3 (
  // Clock and reset
  input  wire logic clock,
  input  wire logic clk_en,
  input  wire logic arst_n,
  // Asynchronous level in, rising event out
  input  wire logic async_in,
  output logic      rise
);
  logic [2:0] sh_ff;
  logic [2:0] nxt_sh;
  logic       lvl_ff;
  logic       nxt_lvl;

  always_comb begin
    nxt_sh  = {sh_ff[1:0], async_in};
    nxt_lvl = (sh_ff[1] == sh_ff[2]) ? sh_ff[2] : lvl_ff;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sh_ff  <= 3'h0;
      lvl_ff <= 1'b0;
    end else if (clk_en) begin
      sh_ff  <= nxt_sh;
      lvl_ff <= nxt_lvl;
    end
  end

  // Counts once the second and third stage agree
  assign rise = sh_ff[1] & sh_ff[2] & ~lvl_ff;
endmodule
`default_nettype wire

/* core/fsr_latch_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module fsr_latch_mem #(
  parameter int DW    = 32,
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          clk_en,
  input  wire logic          arst_n,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port, data one cycle later
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] nxt_rdata;

  always_comb begin
    nxt_rdata = re ? mem[raddr] : rdata;
  end

  always_ff @(posedge clock) begin
    if (clk_en && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else if (clk_en) begin
      rdata <= nxt_rdata;
    end
  end
endmodule
`default_nettype wire

/* core/fsr_row_rewrite.sv */
// Functional notes
// - One row is 512 bytes, rewritten whole.
// - Pre-program and erase first, then program.
// - Other sectors stay readable during the operation.
// - Non-blocking phase one returns, channel stays held.
// - Erase-done interrupt starts phase two, programming.
// - Program-done interrupt ends call, releases channel.
// - Blocking selector 0x01 returns only at end.
// - No write permission gives fail, no write.
// - Verify mismatch returns code 0xF0000022.
// - Stall bit stalls all reads until done.
// - Pulse bit selects firmware or hardware timing.
// - Result nibble 0xA success, 0xF error.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module fsr_row_rewrite
  import fsr_pkg::*;
#(
  parameter int ROW_WORDS = ROW_BYTES / WORD_BYTES
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     clk_en,
  input  wire logic                     arst_n,
  // Register port
  input  wire logic [ADDR_W-1:0]        reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rdata,
  output logic                          irq,
  // Parameter block read port
  output logic                          sram_rd,
  output logic      [31:0]              sram_addr,
  input  wire logic [31:0]              sram_rdata,
  // Protection unit
  output logic      [31:0]              mpu_addr,
  input  wire logic                     mpu_wr_ok,
  // Flash array
  output logic                          fl_start,
  output fsr_fop_t                      fl_op,
  output logic      [31-ROW_SHIFT:0]    fl_row,
  output logic                          fl_hv_hw,
  output logic                          fl_wr,
  output logic [$clog2(ROW_WORDS)-1:0]  fl_widx,
  output logic      [31:0]              fl_wdata,
  output logic                          fl_rd,
  output logic [$clog2(ROW_WORDS)-1:0]  fl_ridx,
  input  wire logic [31:0]              fl_rdata,
  input  wire logic                     fl_done_async,
  output logic                          row_locked,
  output logic                          rd_stall_all
);
  localparam int AW = $clog2(ROW_WORDS);
  localparam int IW = $clog2(ROW_WORDS + HDR_WORDS + 1);
  localparam logic [IW-1:0] FETCH_N = IW'(ROW_WORDS + HDR_WORDS);
  localparam logic [IW-1:0] ROW_N   = IW'(ROW_WORDS);
  localparam logic [IW-1:0] HDR_N   = IW'(HDR_WORDS);
  localparam logic [IW-1:0] IDX_ONE = IW'(1);

  // ------------------------------------------------------------
  // Sequencer state
  // ------------------------------------------------------------
  fsr_state_t    st_ff, nxt_st;
  fsr_fop_t      fop_ff, nxt_fop;
  logic [IW-1:0] iss_ff, nxt_iss;
  logic [IW-1:0] cap_ff, nxt_cap;
  logic          pend_ff, nxt_pend;
  logic          issued_ff, nxt_issued;
  logic          start_ff, nxt_start;
  logic [31:0]   ptr_ff, nxt_ptr;
  logic [31:0]   w0_ff, nxt_w0;
  logic [31:0]   w1_ff, nxt_w1;
  logic [31:0]   tgt_ff, nxt_tgt;
  logic [31:0]   arg_ff, nxt_arg;
  logic [27:0]   err_ff, nxt_err;
  logic [IRQ_W-1:0] ev;
  logic          done_p;
  logic          lat_we, lat_re;
  logic [31:0]   lat_rdata;
  logic          blocking, verify_req, arg_wr, op_act;

  fsr_sync3 u_done_sync (
    .clock    (clock),
    .clk_en   (clk_en),
    .arst_n   (arst_n),
    .async_in (fl_done_async),
    .rise     (done_p)
  );

  fsr_latch_mem #(
    .DW    (32),
    .DEPTH (ROW_WORDS),
    .AW    (AW)
  ) u_latch (
    .clock  (clock),
    .clk_en (clk_en),
    .arst_n (arst_n),
    .we     (lat_we),
    .waddr  (AW'(cap_ff - HDR_N)),
    .wdata  (sram_rdata),
    .re     (lat_re),
    .raddr  (AW'(iss_ff)),
    .rdata  (lat_rdata)
  );

  assign blocking   = w0_ff[BLK_LO +: FIELD_W] == BLOCKING_ON;
  assign verify_req = w1_ff[VER_LO +: FIELD_W] == VERIFY_ON;
  assign arg_wr     = reg_wr && (reg_addr == REG_CALL_ARG);
  assign op_act     = !(st_ff inside {S_IDLE, S_FETCH, S_CHECK, S_DONE});

  always_comb begin
    nxt_st     = st_ff;
    nxt_fop    = fop_ff;
    nxt_iss    = iss_ff;
    nxt_cap    = cap_ff;
    nxt_pend   = 1'b0;
    nxt_issued = issued_ff;
    nxt_start  = 1'b0;
    nxt_ptr    = ptr_ff;
    nxt_w0     = w0_ff;
    nxt_w1     = w1_ff;
    nxt_tgt    = tgt_ff;
    nxt_arg    = arg_ff;
    nxt_err    = err_ff;
    ev         = '0;
    sram_rd    = 1'b0;
    fl_rd      = 1'b0;
    lat_re     = 1'b0;
    lat_we     = 1'b0;
    case (st_ff)
      S_IDLE: begin
        if (arg_wr) begin
          nxt_arg = reg_wdata;
          nxt_ptr = reg_wdata;
          nxt_iss = '0;
          nxt_err = ERR_NONE;
          if (reg_wdata[WORD_SHIFT-1:0] != '0) begin
            nxt_err = ERR_ALIGN;
            nxt_st  = S_DONE;
          end else begin
            nxt_st = S_FETCH;
          end
        end
      end
      S_FETCH: begin
        if (iss_ff != FETCH_N) begin
          sram_rd  = 1'b1;
          nxt_iss  = iss_ff + IDX_ONE;
          nxt_pend = 1'b1;
          nxt_cap  = iss_ff;
        end else if (!pend_ff) begin
          nxt_st = S_CHECK;
        end
        if (pend_ff) begin
          case (cap_ff)
            IW'(0):  nxt_w0  = sram_rdata;
            IW'(1):  nxt_w1  = sram_rdata;
            IW'(2):  nxt_tgt = sram_rdata;
            default: lat_we  = 1'b1;
          endcase
        end
      end
      S_CHECK: begin
        nxt_issued = 1'b0;
        if (w0_ff[OPC_LO +: FIELD_W] != OPC_REWRITE) begin
          nxt_err = ERR_OPCODE;
          nxt_st  = S_DONE;
        end else if (!mpu_wr_ok) begin
          nxt_err = ERR_ACCESS;
          nxt_st  = S_DONE;
        end else begin
          nxt_st = S_PRE;
        end
      end
      S_PRE: begin
        if (!issued_ff) begin
          nxt_start  = 1'b1;
          nxt_fop    = FOP_PREPROG;
          nxt_issued = 1'b1;
        end else if (done_p) begin
          nxt_issued = 1'b0;
          nxt_st     = S_ERASE;
        end
      end
      S_ERASE: begin
        if (!issued_ff) begin
          nxt_start  = 1'b1;
          nxt_fop    = FOP_ERASE;
          nxt_issued = 1'b1;
          if (!blocking) begin
            nxt_arg          = {ST_OK, ERR_NONE};
            ev[IRQ_PHASE]    = 1'b1;
          end
        end else if (done_p) begin
          nxt_issued = 1'b0;
          nxt_iss    = '0;
          nxt_st     = S_FILL;
        end
      end
      S_FILL: begin
        if (iss_ff != ROW_N) begin
          lat_re   = 1'b1;
          nxt_iss  = iss_ff + IDX_ONE;
          nxt_pend = 1'b1;
          nxt_cap  = iss_ff;
        end else if (!pend_ff) begin
          nxt_st = S_PROG;
        end
      end
      S_PROG: begin
        if (!issued_ff) begin
          nxt_start  = 1'b1;
          nxt_fop    = FOP_PROGRAM;
          nxt_issued = 1'b1;
          if (!blocking) begin
            nxt_arg       = {ST_OK, ERR_NONE};
            ev[IRQ_PHASE] = 1'b1;
          end
        end else if (done_p) begin
          nxt_issued = 1'b0;
          nxt_iss    = '0;
          nxt_st     = verify_req ? S_VERIFY : S_DONE;
        end
      end
      S_VERIFY: begin
        if (iss_ff != ROW_N) begin
          lat_re   = 1'b1;
          fl_rd    = 1'b1;
          nxt_iss  = iss_ff + IDX_ONE;
          nxt_pend = 1'b1;
        end else if (!pend_ff) begin
          nxt_st = S_DONE;
        end
        if (pend_ff && (fl_rdata != lat_rdata)) begin
          nxt_err = ERR_VERIFY;
        end
      end
      S_DONE: begin
        nxt_arg     = (err_ff == ERR_NONE) ? {ST_OK, ERR_NONE} : {ST_ERR, err_ff};
        ev[IRQ_DONE] = 1'b1;
        ev[IRQ_ERR]  = err_ff != ERR_NONE;
        nxt_fop      = FOP_NONE;
        nxt_st       = S_IDLE;
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_ff     <= S_IDLE;
      fop_ff    <= FOP_NONE;
      iss_ff    <= '0;
      cap_ff    <= '0;
      pend_ff   <= 1'b0;
      issued_ff <= 1'b0;
      start_ff  <= 1'b0;
      ptr_ff    <= '0;
      w0_ff     <= '0;
      w1_ff     <= '0;
      tgt_ff    <= '0;
      arg_ff    <= '0;
      err_ff    <= ERR_NONE;
    end else if (clk_en) begin
      st_ff     <= nxt_st;
      fop_ff    <= nxt_fop;
      iss_ff    <= nxt_iss;
      cap_ff    <= nxt_cap;
      pend_ff   <= nxt_pend;
      issued_ff <= nxt_issued;
      start_ff  <= nxt_start;
      ptr_ff    <= nxt_ptr;
      w0_ff     <= nxt_w0;
      w1_ff     <= nxt_w1;
      tgt_ff    <= nxt_tgt;
      arg_ff    <= nxt_arg;
      err_ff    <= nxt_err;
    end
  end

  // ------------------------------------------------------------
  // Flash and memory side
  // ------------------------------------------------------------
  assign sram_addr    = ptr_ff + (32'(iss_ff) << WORD_SHIFT);
  assign mpu_addr     = tgt_ff;
  assign fl_start     = start_ff;
  assign fl_op        = fop_ff;
  assign fl_row       = tgt_ff[31:ROW_SHIFT];
  assign fl_hv_hw     = op_act && w0_ff[HWP_BIT];
  assign fl_wr        = pend_ff && (st_ff == S_FILL);
  assign fl_widx      = AW'(cap_ff);
  assign fl_wdata     = lat_rdata;
  assign fl_ridx      = AW'(iss_ff);
  assign row_locked   = op_act;
  assign rd_stall_all = op_act && w0_ff[STALL_BIT];

  // ------------------------------------------------------------
  // Register port and interrupt
  // ------------------------------------------------------------
  logic [31:0]      rdata_ff, nxt_rdata;
  logic [IRQ_W-1:0] sts_ff, nxt_sts;
  logic [IRQ_W-1:0] en_ff, nxt_en;
  logic [1:0]       phase;

  always_comb begin
    case (st_ff)
      S_FILL, S_PROG:   phase = 2'h2;
      S_VERIFY, S_DONE: phase = 2'h3;
      S_IDLE:           phase = 2'h0;
      default:          phase = 2'h1;
    endcase
  end

  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_en    = en_ff;
    nxt_sts   = sts_ff;
    if (reg_wr && (reg_addr == REG_IRQ_CLR)) begin
      nxt_sts = sts_ff & ~reg_wdata[IRQ_W-1:0];
    end
    nxt_sts = nxt_sts | ev;
    if (reg_wr && (reg_addr == REG_IRQ_EN)) begin
      nxt_en = reg_wdata[IRQ_W-1:0];
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CALL_ARG: nxt_rdata = arg_ff;
        REG_STATUS:   nxt_rdata = {28'h0, phase, rd_stall_all, st_ff != S_IDLE};
        REG_IRQ_STS:  nxt_rdata = {29'h0, sts_ff};
        REG_IRQ_EN:   nxt_rdata = {29'h0, en_ff};
        default:      nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= '0;
      sts_ff   <= '0;
      en_ff    <= '0;
    end else if (clk_en) begin
      rdata_ff <= nxt_rdata;
      sts_ff   <= nxt_sts;
      en_ff    <= nxt_en;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq       = |(sts_ff & en_ff);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  localparam int VER_MAX = 300;
  logic [IW-1:0] wcnt_ff;
  logic          erased_ff;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wcnt_ff   <= '0;
      erased_ff <= 1'b0;
    end else if (clk_en) begin
      wcnt_ff   <= (st_ff == S_IDLE) ? '0 : wcnt_ff + IW'(fl_wr);
      erased_ff <= (st_ff == S_IDLE) ? 1'b0 : erased_ff | (st_ff == S_ERASE && issued_ff && done_p);
    end
  end

  default clocking cb @(posedge clock iff clk_en);
  endclocking
  default disable iff (!arst_n);

  sequence s_denied;
    st_ff == S_CHECK && w0_ff[OPC_LO +: FIELD_W] == OPC_REWRITE && !mpu_wr_ok;
  endsequence
  sequence s_erase_end;
    st_ff == S_ERASE && issued_ff && done_p;
  endsequence
  sequence s_prog_end;
    st_ff == S_PROG && issued_ff && done_p;
  endsequence

  chk_row_words: assert property ($rose(st_ff == S_PROG) |-> wcnt_ff == ROW_N)
    else $error("row fill count wrong");
  chk_erase_first: assert property (fl_start && fl_op == FOP_PROGRAM |-> erased_ff)
    else $error("program before erase");
  chk_rww_lock: assert property (op_act && !w0_ff[STALL_BIT] |-> row_locked && !rd_stall_all)
    else $error("other sectors blocked");
  chk_channel_held: assert property (st_ff != S_IDLE && arg_wr |=> $stable(ptr_ff))
    else $error("new call accepted while held");
  chk_phase_two: assert property (s_erase_end |=> st_ff == S_FILL ##[1:VER_MAX] fl_start)
    else $error("erase end did not start programming");
  chk_phase_three: assert property (s_prog_end |=> st_ff inside {S_VERIFY, S_DONE} ##[1:VER_MAX] st_ff == S_IDLE)
    else $error("call not released");
  chk_block_quiet: assert property (st_ff != S_IDLE && blocking |-> !ev[IRQ_PHASE])
    else $error("blocking call returned early");
  chk_denied: assert property (s_denied |=> st_ff == S_DONE ##1 (arg_ff == {ST_ERR, ERR_ACCESS} && !fl_start))
    else $error("denied call not failed");
  chk_verify_code: assert property (st_ff == S_VERIFY && pend_ff && fl_rdata != lat_rdata |=> ##[1:VER_MAX] arg_ff == {ST_ERR, ERR_VERIFY})
    else $error("verify mismatch not reported");
  chk_stall_all: assert property (op_act |-> rd_stall_all == w0_ff[STALL_BIT])
    else $error("read stall wrong");
  chk_hv_select: assert property (op_act |-> fl_hv_hw == w0_ff[HWP_BIT])
    else $error("pulse timing select wrong");
  chk_result_nibble: assert property (
    ev[IRQ_DONE] |=> arg_ff[31:28] == ($past(ev[IRQ_ERR]) ? ST_ERR : ST_OK))
    else $error("result nibble wrong");
endmodule
`default_nettype wire

/* bench/fsr_flash_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fsr_flash_model
  import fsr_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Bench setup
  input  wire logic [31:0] ptr,
  input  wire logic [31:0] hdr0,
  input  wire logic [31:0] hdr1,
  input  wire logic [31:0] tgt,
  input  wire logic        slow,
  input  wire logic        corrupt,
  // Parameter block port
  input  wire logic        sram_rd,
  input  wire logic [31:0] sram_addr,
  output logic      [31:0] sram_rdata,
  // Flash array port
  input  wire logic        fl_start,
  input  wire logic        fl_wr,
  input  wire logic [6:0]  fl_widx,
  input  wire logic [31:0] fl_wdata,
  input  wire logic        fl_rd,
  input  wire logic [6:0]  fl_ridx,
  output logic      [31:0] fl_rdata,
  output logic             fl_done_async
);
  logic [31:0] row [128];
  logic [31:0] idx;
  logic [7:0]  cnt;

  assign idx = (sram_addr - ptr) >> WORD_SHIFT;

  // Caller memory; data toggles when not read
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sram_rdata <= 32'h0;
    end else if (sram_rd) begin
      case (idx)
        32'h0:   sram_rdata <= hdr0;
        32'h1:   sram_rdata <= hdr1;
        32'h2:   sram_rdata <= tgt;
        default: sram_rdata <= 32'h5A00_0000 + idx - 32'h3;
      endcase
    end else begin
      sram_rdata <= ~sram_rdata;
    end
  end

  // Row store, verify port and done level
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fl_rdata      <= 32'h0;
      fl_done_async <= 1'b0;
      cnt           <= 8'h00;
    end else begin
      if (fl_wr)
        row[fl_widx] <= fl_wdata;
      fl_rdata <= fl_rd ? row[fl_ridx] ^ {31'h0, corrupt} : ~fl_rdata;
      if (fl_start) begin
        fl_done_async <= 1'b0;
        cnt           <= slow ? 8'h28 : 8'h05;
      end else if (cnt != 8'h00) begin
        cnt           <= cnt - 8'h01;
        fl_done_async <= (cnt == 8'h01);
      end
    end
  end
endmodule
`default_nettype wire

/* bench/fsr_row_rewrite_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module fsr_row_rewrite_tb
  import fsr_pkg::*;
;
  localparam logic [31:0] PTR = 32'h0000_1000;
  localparam logic [31:0] TGT = 32'h1000_0400;

  logic        clock, arst_n, reg_wr, reg_rd, irq, sram_rd, mpu_wr_ok;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, sram_addr, sram_rdata, mpu_addr;
  logic        fl_start, fl_hv_hw, fl_wr, fl_rd, fl_done_async;
  logic        row_locked, rd_stall_all, slow, corrupt;
  logic        clk_en, mon_clr;
  fsr_fop_t    fl_op;
  logic [22:0] fl_row;
  logic [6:0]  fl_widx, fl_ridx;
  logic [31:0] fl_wdata, fl_rdata, hdr0, hdr1, rd_val;
  logic [5:0]  ops;
  logic        saw_stall, saw_lock, saw_hw;
  int          fail_count, tests_run, n_start, n_wr;

  fsr_row_rewrite i_dut (
    .clock(clock), .clk_en(clk_en), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .sram_rd(sram_rd), .sram_addr(sram_addr), .sram_rdata(sram_rdata),
    .mpu_addr(mpu_addr), .mpu_wr_ok(mpu_wr_ok),
    .fl_start(fl_start), .fl_op(fl_op), .fl_row(fl_row), .fl_hv_hw(fl_hv_hw),
    .fl_wr(fl_wr), .fl_widx(fl_widx), .fl_wdata(fl_wdata), .fl_rd(fl_rd),
    .fl_ridx(fl_ridx), .fl_rdata(fl_rdata), .fl_done_async(fl_done_async),
    .row_locked(row_locked), .rd_stall_all(rd_stall_all)
  );

  fsr_flash_model i_model (
    .clock(clock), .arst_n(arst_n), .ptr(PTR), .hdr0(hdr0), .hdr1(hdr1), .tgt(TGT),
    .slow(slow), .corrupt(corrupt), .sram_rd(sram_rd),
    .sram_addr(sram_addr), .sram_rdata(sram_rdata), .fl_start(fl_start),
    .fl_wr(fl_wr), .fl_widx(fl_widx), .fl_wdata(fl_wdata), .fl_rd(fl_rd),
    .fl_ridx(fl_ridx), .fl_rdata(fl_rdata), .fl_done_async(fl_done_async)
  );

  always #12.5 clock = ~clock;

  // Watches flash commands and stall levels
  always @(posedge clock) begin
    if (mon_clr) begin
      ops       <= 6'h00;
      n_start   <= 0;
      n_wr      <= 0;
      saw_stall <= 1'b0;
      saw_lock  <= 1'b0;
      saw_hw    <= 1'b0;
    end else begin
      if (fl_start) begin
        ops     <= {ops[3:0], fl_op};
        n_start <= n_start + 1;
      end
      if (fl_wr)
        n_wr <= n_wr + 1;
      saw_stall <= saw_stall | rd_stall_all;
      saw_lock  <= saw_lock | row_locked;
      saw_hw    <= saw_hw | fl_hv_hw;
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int k;
    k = 0;
    rd(a);
    while (rd_val[b] !== v) begin
      k++;
      if (k > 1500) begin
        fail_count++;
        $display("[ERR] wait %h expected %b seen %b", a, v, rd_val[b]);
        close_out();
      end
      rd(a);
    end
  endtask

  task automatic start(input logic [7:0] blk, input logic [1:0] opt, input logic [7:0] ver);
    hdr0      = {OPC_REWRITE, 8'h00, blk, 5'h00, opt, 1'b0};
    hdr1      = {8'h00, ver, 16'h0000};
    mon_clr <= 1'b1;
    @(posedge clock);
    mon_clr <= 1'b0;
    wr(REG_IRQ_CLR, 32'h7);
    wr(REG_CALL_ARG, PTR);
  endtask

  task automatic chk_row();
    int bad;
    bad = 0;
    for (int n = 0; n < ROW_BYTES / WORD_BYTES; n++)
      if (i_model.row[n] !== 32'h5A00_0000 + n)
        bad++;
    chk("row data errors", bad, 0);
    chk("row word writes", n_wr, ROW_BYTES / WORD_BYTES);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(REG_STATUS);
    chk("status after reset", rd_val, 32'h0);
    rd(8'h14);
    chk("unmapped read", rd_val, 32'h0);
    chk("irq after reset", {31'h0, irq}, 32'h0);
    clk_en <= 1'b0;
    wr(REG_IRQ_EN, 32'h7);
    clk_en <= 1'b1;
    rd(REG_IRQ_EN);
    chk("write while frozen", rd_val, 32'h0);
  endtask

  task automatic t_blocking();
    wr(REG_IRQ_EN, 32'h0);
    start(BLOCKING_ON, 2'b11, VERIFY_ON);
    poll(REG_STATUS, STAT_BUSY, 1'b0);
    rd(REG_CALL_ARG);
    chk("blocking result", rd_val, {ST_OK, ERR_NONE});
    rd(REG_IRQ_STS);
    chk("blocking events", rd_val, 32'h2);
    chk("op order", {26'h0, ops}, {26'h0, FOP_PREPROG, FOP_ERASE, FOP_PROGRAM});
    chk("target row", {9'h0, fl_row}, {9'h0, TGT[31:9]});
    chk("checked address", mpu_addr, TGT);
    chk("stall and pulse", {30'h0, saw_stall, saw_hw}, 32'h3);
    chk("stall released", {31'h0, rd_stall_all}, 32'h0);
    chk("masked irq", {31'h0, irq}, 32'h0);
    chk_row();
  endtask

  task automatic t_nonblock();
    slow = 1'b1;
    wr(REG_IRQ_EN, 32'h2);
    start(8'h00, 2'b00, 8'h00);
    poll(REG_IRQ_STS, IRQ_PHASE, 1'b1);
    rd(REG_CALL_ARG);
    chk("phase one result", rd_val, {ST_OK, ERR_NONE});
    rd(REG_STATUS);
    chk("phase one status", {28'h0, rd_val[3:0]}, 32'h5);
    wr(REG_CALL_ARG, PTR + 32'h100);
    wr(REG_IRQ_CLR, 32'h1);
    poll(REG_IRQ_STS, IRQ_PHASE, 1'b1);
    rd(REG_STATUS);
    chk("phase two status", {28'h0, rd_val[3:0]}, 32'h9);
    chk("phase event masked", {31'h0, irq}, 32'h0);
    poll(REG_STATUS, STAT_BUSY, 1'b0);
    chk("irq on done", {31'h0, irq}, 32'h1);
    rd(REG_IRQ_STS);
    chk("final events", rd_val, 32'h3);
    chk("held call runs once", n_start, 3);
    chk("lock only", {29'h0, saw_stall, saw_hw, saw_lock}, 32'h1);
    chk_row();
    wr(REG_IRQ_CLR, 32'h7);
    rd(REG_IRQ_STS);
    chk("events cleared", {rd_val[31:1], irq}, 32'h0);
    slow = 1'b0;
  endtask

  task automatic t_verify();
    corrupt = 1'b1;
    start(BLOCKING_ON, 2'b00, VERIFY_ON);
    poll(REG_STATUS, STAT_BUSY, 1'b0);
    rd(REG_CALL_ARG);
    chk("verify mismatch", rd_val, {ST_ERR, ERR_VERIFY});
    rd(REG_IRQ_STS);
    chk("verify events", rd_val, 32'h6);
    start(BLOCKING_ON, 2'b00, 8'h00);
    poll(REG_STATUS, STAT_BUSY, 1'b0);
    rd(REG_CALL_ARG);
    chk("verify skipped", rd_val, {ST_OK, ERR_NONE});
    corrupt = 1'b0;
  endtask

  task automatic t_denied();
    mpu_wr_ok <= 1'b0;
    start(BLOCKING_ON, 2'b00, VERIFY_ON);
    poll(REG_STATUS, STAT_BUSY, 1'b0);
    rd(REG_CALL_ARG);
    chk("denied result", rd_val, {ST_ERR, ERR_ACCESS});
    chk("denied flash ops", n_start + n_wr, 0);
    mpu_wr_ok <= 1'b1;
  endtask

  // Reset is applied only before any call
  initial begin
    clock      = 1'b0;
    arst_n     = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 32'h0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    mpu_wr_ok  = 1'b1;
    clk_en     = 1'b1;
    mon_clr    = 1'b1;
    slow       = 1'b0;
    corrupt    = 1'b0;
    hdr0       = 32'h0;
    hdr1       = 32'h0;
    fail_count = 0;
    tests_run  = 0;
    repeat (6) @(posedge clock);
    arst_n  <= 1'b1;
    mon_clr <= 1'b0;
    repeat (2) @(posedge clock);
    t_reset();
    t_blocking();
    t_nonblock();
    t_verify();
    t_denied();
    close_out();
  end
endmodule
`default_nettype wire
